// ---- hdl/dwr_top.v ----
`timescale 1ns/1ps
`include "dwr_consts.vh"
// ==========================================================
// Device-wide clear and power-up control, AXI4-Lite slave
module dwr_top #(
  parameter [`DWR_NCELL-1:0] P_PUP_LEVEL = `DWR_PUP_DEFAULT
) (
  input wire i_mclk,
  input wire i_reset,
  // Clear pin, three signals of a two-way pin
  input wire i_device_wide_clear_pin_low,
  output wire o_clear_pin_out,
  output wire o_clear_pin_oe,
  // Clock control
  output wire o_gate_en,
  output wire o_clknet_pwrdn,
  // User register outputs
  output wire [`DWR_NCELL-1:0] o_cells,
  // AXI4-Lite write address
  input wire i_awvalid,
  output wire o_awready,
  input wire [`DWR_AW-1:0] i_awaddr,
  input wire [2:0] i_awprot,
  // AXI4-Lite write data
  input wire i_wvalid,
  output wire o_wready,
  input wire [`DWR_DW-1:0] i_wdata,
  input wire [3:0] i_wstrb,
  // AXI4-Lite write response
  output wire o_bvalid,
  input wire i_bready,
  output wire [1:0] o_bresp,
  // AXI4-Lite read address
  input wire i_arvalid,
  output wire o_arready,
  input wire [`DWR_AW-1:0] i_araddr,
  input wire [2:0] i_arprot,
  // AXI4-Lite read data
  output wire o_rvalid,
  input wire i_rready,
  output wire [`DWR_DW-1:0] o_rdata,
  output wire [1:0] o_rresp
);

  // ==========================================================
  // Helpers

  // Byte-lane merge of a write into an old word
  function [`DWR_DW-1:0] merge;
    input [`DWR_DW-1:0] old;
    input [`DWR_DW-1:0] nw;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Address lies in the memory window
  function is_mem;
    input [`DWR_AW-1:0] a;
    begin
      is_mem = (a >= `DWR_OFS_MEM);
    end
  endfunction

  // Address names a known register or the memory window
  function is_mapped;
    input [`DWR_AW-1:0] a;
    begin
      if (is_mem(a)) begin
        is_mapped = 1'b1;
      end else if (a == `DWR_OFS_CTRL || a == `DWR_OFS_STATUS) begin
        is_mapped = 1'b1;
      end else if (a == `DWR_OFS_PIN || a == `DWR_OFS_PRESET) begin
        is_mapped = 1'b1;
      end else if (a == `DWR_OFS_HOLD || a == `DWR_OFS_DATA) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // ==========================================================
  // Pin synchroniser and clear qualification

  reg pin_meta_q;
  reg pin_sync_q;
  reg [2:0] ctrl_q;
  reg [1:0] pin_mode_q;
  reg gate_q;
  reg pwrdn_q;
  wire clear_en;
  wire dev_clear;

  // Two flops before any logic sees the pin; idle level is released
  always @(posedge i_mclk) begin
    if (i_reset) begin
      pin_meta_q <= `DWR_PIN_IDLE;
      pin_sync_q <= `DWR_PIN_IDLE;
    end else begin
      pin_meta_q <= i_device_wide_clear_pin_low;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign clear_en = ctrl_q[`DWR_CTRL_CLR_EN];
  assign dev_clear = clear_en & ~pin_sync_q;

  assign o_clear_pin_oe = ~clear_en & pin_mode_q[`DWR_PIN_OE];
  assign o_clear_pin_out = pin_mode_q[`DWR_PIN_OUT];

  // ==========================================================
  // AXI4-Lite write channel

  reg aw_hold_q;
  reg [`DWR_AW-1:0] awaddr_q;
  reg w_hold_q;
  reg [`DWR_DW-1:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  wire aw_fire;
  wire w_fire;
  wire wr_go;
  wire [`DWR_AW-1:0] wa;

  assign o_awready = ~aw_hold_q & ~bvalid_q;
  assign o_wready = ~w_hold_q & ~bvalid_q;
  assign aw_fire = i_awvalid & o_awready;
  assign w_fire = i_wvalid & o_wready;
  // Write happens once both halves are held and no answer is pending
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wa = {awaddr_q[`DWR_AW-1:2], 2'b00};

  // Address and data are caught in either order
  always @(posedge i_mclk) begin
    if (i_reset) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= {`DWR_AW{1'b0}};
      w_hold_q <= 1'b0;
      wdata_q <= {`DWR_DW{1'b0}};
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `DWR_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (w_fire) begin
        w_hold_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(wa) ? `DWR_RESP_OKAY : `DWR_RESP_SLVERR;
      end else if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  // ==========================================================
  // Control registers

  reg [`DWR_NCELL-1:0] hold_q;
  wire [`DWR_DW-1:0] ctrl_new;
  wire [`DWR_DW-1:0] pin_new;
  wire [`DWR_DW-1:0] hold_new;
  wire wr_ctrl;
  wire wr_pin;
  wire wr_hold;
  wire wr_data;
  wire wr_preset;

  assign wr_ctrl = wr_go & (wa == `DWR_OFS_CTRL);
  assign wr_pin = wr_go & (wa == `DWR_OFS_PIN);
  assign wr_hold = wr_go & (wa == `DWR_OFS_HOLD);
  assign wr_data = wr_go & (wa == `DWR_OFS_DATA);
  assign wr_preset = wr_go & (wa == `DWR_OFS_PRESET) & wstrb_q[0];
  assign ctrl_new = merge({29'h0, ctrl_q}, wdata_q, wstrb_q);
  assign pin_new = merge({30'h0, pin_mode_q}, wdata_q, wstrb_q);
  assign hold_new = merge({24'h0, hold_q}, wdata_q, wstrb_q);

  // Clear option and pin mode survive the device clear on purpose:
  // clearing them would drop the clear itself mid-assertion
  always @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q <= `DWR_CTRL_RST;
      pin_mode_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_new[2:0];
      end
      if (wr_pin) begin
        pin_mode_q <= pin_new[1:0];
      end
    end
  end

  // Hold mask: bit set lets a data write load that cell
  always @(posedge i_mclk) begin
    if (i_reset) begin
      hold_q <= `DWR_HOLD_RST;
    end else if (dev_clear) begin
      hold_q <= `DWR_HOLD_RST;
    end else if (wr_hold) begin
      hold_q <= hold_new[`DWR_NCELL-1:0];
    end
  end

  // ==========================================================
  // Clock gating and network power-down requests

  always @(posedge i_mclk) begin
    if (i_reset) begin
      gate_q <= 1'b0;
      pwrdn_q <= 1'b0;
    end else begin
      gate_q <= ctrl_q[`DWR_CTRL_GATE];
      pwrdn_q <= ctrl_q[`DWR_CTRL_PWRDN];
    end
  end

  assign o_gate_en = gate_q;
  assign o_clknet_pwrdn = pwrdn_q;

  // ==========================================================
  // User register cells

  wire [`DWR_NCELL-1:0] cells;
  genvar g;

  generate
    for (g = 0; g < `DWR_NCELL; g = g + 1) begin : g_cell
      dwr_cell #(
        .PUP_HIGH(P_PUP_LEVEL[g])
      ) u_cell (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_clear(dev_clear),
        .i_preset(wr_preset & wdata_q[g]),
        .i_en(wr_data & wstrb_q[0] & hold_q[g]),
        .i_d(wdata_q[g]),
        .o_q(cells[g])
      );
    end
  endgenerate

  assign o_cells = cells;

  // ==========================================================
  // AXI4-Lite read channel and memory

  reg rd_busy_q;
  reg [`DWR_AW-1:0] araddr_q;
  reg rvalid_q;
  reg [`DWR_DW-1:0] rdata_q;
  reg [1:0] rresp_q;
  reg [`DWR_DW-1:0] rd_mux;
  wire ar_fire;
  wire [`DWR_AW-1:0] ra;
  wire [`DWR_DW-1:0] mem_rdata;
  wire mem_we;

  assign o_arready = ~rd_busy_q & ~rvalid_q;
  assign ar_fire = i_arvalid & o_arready;
  assign ra = {araddr_q[`DWR_AW-1:2], 2'b00};
  assign mem_we = wr_go & is_mem(wa);

  dwr_mem u_mem (
    .i_mclk(i_mclk),
    .i_clear(i_reset | dev_clear),
    .i_we(mem_we),
    .i_waddr(wa[`DWR_MEM_AW+1:2]),
    .i_wdata(wdata_q),
    .i_wstrb(wstrb_q),
    .i_re(ar_fire),
    .i_raddr(i_araddr[`DWR_MEM_AW+1:2]),
    .o_rdata(mem_rdata)
  );

  // Read mux; reserved bits read zero
  always @* begin
    rd_mux = {`DWR_DW{1'b0}};
    if (is_mem(ra)) begin
      rd_mux = mem_rdata;
    end else if (ra == `DWR_OFS_CTRL) begin
      rd_mux[2:0] = ctrl_q;
    end else if (ra == `DWR_OFS_STATUS) begin
      rd_mux[`DWR_ST_CLR_ACT] = dev_clear;
      rd_mux[`DWR_ST_PIN] = pin_sync_q;
      rd_mux[`DWR_ST_GATE] = gate_q;
      rd_mux[`DWR_ST_PWRDN] = pwrdn_q;
    end else if (ra == `DWR_OFS_PIN) begin
      rd_mux[1:0] = pin_mode_q;
    end else if (ra == `DWR_OFS_HOLD) begin
      rd_mux[`DWR_NCELL-1:0] = hold_q;
    end else if (ra == `DWR_OFS_DATA) begin
      rd_mux[`DWR_NCELL-1:0] = cells;
    end
  end

  // Answer one cycle after the address is taken, when memory data lands
  always @(posedge i_mclk) begin
    if (i_reset) begin
      rd_busy_q <= 1'b0;
      araddr_q <= {`DWR_AW{1'b0}};
      rvalid_q <= 1'b0;
      rdata_q <= {`DWR_DW{1'b0}};
      rresp_q <= `DWR_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rd_busy_q <= 1'b1;
        araddr_q <= i_araddr;
      end else if (rd_busy_q) begin
        rd_busy_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= is_mapped(ra) ? `DWR_RESP_OKAY : `DWR_RESP_SLVERR;
      end else if (rvalid_q & i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

endmodule

// ---- common/dwr_consts.vh ----
// ==========================================================
// Block constants
`ifndef DWR_CONSTS_VH
`define DWR_CONSTS_VH

// Bus geometry
`define DWR_AW 7
`define DWR_DW 32
`define DWR_NCELL 8
`define DWR_MEM_DEPTH 16
`define DWR_MEM_AW 4

// Register byte offsets
`define DWR_OFS_CTRL 7'h00
`define DWR_OFS_STATUS 7'h04
`define DWR_OFS_PIN 7'h08
`define DWR_OFS_PRESET 7'h0c
`define DWR_OFS_HOLD 7'h10
`define DWR_OFS_DATA 7'h14
`define DWR_OFS_MEM 7'h40

// Control fields
`define DWR_CTRL_CLR_EN 0
`define DWR_CTRL_GATE 1
`define DWR_CTRL_PWRDN 2

// Status fields
`define DWR_ST_CLR_ACT 0
`define DWR_ST_PIN 1
`define DWR_ST_GATE 2
`define DWR_ST_PWRDN 3

// Pin-mode fields
`define DWR_PIN_OUT 0
`define DWR_PIN_OE 1

// Reset values
`define DWR_CTRL_RST 3'h0
`define DWR_HOLD_RST 8'h00
`define DWR_PUP_DEFAULT 8'h00
`define DWR_PIN_IDLE 1'h1

// Responses
`define DWR_RESP_OKAY 2'h0
`define DWR_RESP_SLVERR 2'h2

`endif

// ---- hdl/dwr_cell.v ----
`timescale 1ns/1ps
// ==========================================================
// One user register with power-up level, clear, preset, enable
module dwr_cell #(
  parameter [0:0] PUP_HIGH = 1'b0
) (
  input wire i_mclk,
  input wire i_reset,
  input wire i_clear,
  input wire i_preset,
  input wire i_en,
  input wire i_d,
  output wire o_q
);

  reg cell_q;

  // Clear wins over preset, preset over data; the clock never stops
  always @(posedge i_mclk) begin
    if (i_reset) begin
      cell_q <= PUP_HIGH;
    end else if (i_clear) begin
      cell_q <= 1'b0;
    end else if (i_preset) begin
      cell_q <= 1'b1;
    end else if (i_en) begin
      cell_q <= i_d;
    end
  end

  // holds until clear, preset or an enabled data load
  assign o_q = cell_q;

endmodule

// ---- hdl/dwr_mem.v ----
`timescale 1ns/1ps
`include "dwr_consts.vh"
// ==========================================================
// Embedded memory block with whole-array clear
module dwr_mem (
  input wire i_mclk,
  input wire i_clear,
  input wire i_we,
  input wire [`DWR_MEM_AW-1:0] i_waddr,
  input wire [`DWR_DW-1:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_re,
  input wire [`DWR_MEM_AW-1:0] i_raddr,
  output wire [`DWR_DW-1:0] o_rdata
);

  reg [`DWR_DW-1:0] mem_q [0:`DWR_MEM_DEPTH-1];
  reg [`DWR_DW-1:0] rdata_q;
  integer w;
  integer b;

  always @(posedge i_mclk) begin
    if (i_clear) begin
      for (w = 0; w < `DWR_MEM_DEPTH; w = w + 1) begin
        mem_q[w] <= {`DWR_DW{1'b0}};
      end
    end else if (i_we) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (i_wstrb[b]) begin
          mem_q[i_waddr][b*8 +: 8] <= i_wdata[b*8 +: 8];
        end
      end
    end
  end

  // Read data register is cleared too, so no stale word leaks out
  always @(posedge i_mclk) begin
    if (i_clear) begin
      rdata_q <= {`DWR_DW{1'b0}};
    end else if (i_re) begin
      rdata_q <= mem_q[i_raddr];
    end
  end

  assign o_rdata = rdata_q;

endmodule

// ---- bench/dwr_props.sv ----
`timescale 1ns/1ps
`include "dwr_consts.vh"
// ==========================================================
// Port-level checks of clear, power-up and bus timing
module dwr_props #(
  parameter [7:0] P_PUP_LEVEL = 8'h00
) (
  input wire i_mclk,
  input wire i_reset,
  input wire i_device_wide_clear_pin_low,
  input wire o_clear_pin_oe,
  input wire [7:0] o_cells,
  input wire i_awvalid,
  input wire o_awready,
  input wire [6:0] i_awaddr,
  input wire i_wvalid,
  input wire o_wready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire o_bvalid,
  input wire i_bready,
  input wire [1:0] o_bresp,
  input wire i_arvalid,
  input wire o_arready,
  input wire o_rvalid,
  input wire i_rready,
  input wire [31:0] o_rdata
);
  reg aw_q, w_q, en_q, s_q, d_q;
  reg [6:0] a_q;
  // Mirror of the clear-enable bit, updated on the same edge as the register
  always @(posedge i_mclk) begin
    if (i_reset) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      en_q <= 1'b0;
    end else if (aw_q && w_q) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      if (a_q == `DWR_OFS_CTRL && s_q) en_q <= d_q;
    end else begin
      if (i_awvalid && o_awready) aw_q <= 1'b1;
      if (i_awvalid && o_awready) a_q <= i_awaddr;
      if (i_wvalid && o_wready) w_q <= 1'b1;
      if (i_wvalid && o_wready) s_q <= i_wstrb[0];
      if (i_wvalid && o_wready) d_q <= i_wdata[0];
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // Assertions
  a_reset_state: assert property ($fell(i_reset) |-> o_cells == P_PUP_LEVEL
    && !o_bvalid && !o_rvalid) else $error("bad state after reset");
  a_cells_clear: assert property ((!i_device_wide_clear_pin_low && en_q)[*3]
    |=> o_cells == 8'h00) else $error("cells not cleared");
  a_pin_oe_off: assert property (en_q |-> !o_clear_pin_oe)
    else $error("pin driven while clear enabled");
  a_write_answer: assert property (aw_q && w_q |=> o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> !o_rvalid ##1 o_rvalid)
    else $error("read response timing");
  a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while busy");
  a_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  c_write: cover property (aw_q && w_q);
  c_clear: cover property ((!i_device_wide_clear_pin_low && en_q)[*3]);
  c_read: cover property (o_rvalid && i_rready);
endmodule

bind dwr_top dwr_props #(.P_PUP_LEVEL(P_PUP_LEVEL)) i_dwr_props (
  .i_mclk, .i_reset, .i_device_wide_clear_pin_low, .o_clear_pin_oe, .o_cells,
  .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
  .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
  .o_rdata
);

// ---- bench/dwr_board.sv ----
`timescale 1ns/1ps
// ==========================================================
// Board logic on the clear pin, with a pull-up when undriven
module dwr_board (
  input wire i_mclk,
  input wire i_hold_low,
  input wire i_dev_oe,
  input wire i_dev_out,
  output wire o_pin
);
  reg low_q = 1'b0;
  always @(posedge i_mclk) begin
    low_q <= i_hold_low;
  end
  // Device drive wins; otherwise board level or pull-up
  assign o_pin = i_dev_oe ? i_dev_out : !low_q;
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "dwr_consts.vh"
// ==========================================================
// Self-checking bench for clear and power-up control
module tb_top;
  localparam [7:0] PUP = 8'h81;
  localparam [1:0] OK = `DWR_RESP_OKAY;
  localparam [1:0] ER = `DWR_RESP_SLVERR;
  reg clk, rst, awv, wv, brdy, arv, rrdy, hold_low;
  reg [6:0] awa, ara;
  reg [31:0] wd;
  reg [3:0] ws;
  wire awr, wrdy, bv, arr, rv, pin, pout, poe, gate, pwrdn;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [7:0] cells;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  dwr_top #(.P_PUP_LEVEL(PUP)) i_dwr_top (.i_mclk(clk), .i_reset(rst),
    .i_device_wide_clear_pin_low(pin), .o_clear_pin_out(pout), .o_clear_pin_oe(poe),
    .o_gate_en(gate), .o_clknet_pwrdn(pwrdn), .o_cells(cells),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_awprot(3'h0),
    .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(ws),
    .o_bvalid(bv), .i_bready(brdy), .o_bresp(br),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0),
    .o_rvalid(rv), .i_rready(rrdy), .o_rdata(rdat), .o_rresp(rr));
  dwr_board i_dwr_board (.i_mclk(clk), .i_hold_low(hold_low), .i_dev_oe(poe),
    .i_dev_out(pout), .o_pin(pin));
  // ==========================================================
  // Shared tasks
  task automatic chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input [6:0] a, input [31:0] d, input [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    // Let an edge pass so bready is never lowered and raised in one step
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!ad || !dd) begin
      @(posedge clk);
      if (awv && awr) begin
        ad = 1;
        awv <= 1'b0;
      end
      if (wv && wrdy) begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    brdy <= 1'b0;
    chk(br, er);
  endtask
  task automatic rd(input [6:0] a, input [31:0] exp, input [1:0] er);
    // Let an edge pass so rready is never lowered and raised in one step
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rrdy <= 1'b0;
    chk(rdat, exp);
    chk(rr, er);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_powerup;
    chk(cells, PUP);
    chk({poe, gate, pwrdn}, 3'h0);
    rd(`DWR_OFS_CTRL, 0, OK);
  endtask
  // Enable chooses between hold and load; high level kept until low data
  task automatic t_hold;
    wr(`DWR_OFS_HOLD, 32'h0f, OK);
    wr(`DWR_OFS_DATA, 32'h00, OK);
    chk(cells, 8'h80);
    wr(`DWR_OFS_HOLD, 32'h00, OK);
    wr(`DWR_OFS_DATA, 32'hff, OK);
    rd(`DWR_OFS_DATA, 32'h80, OK);
    wr(`DWR_OFS_PRESET, 32'h06, OK);
    chk(cells, 8'h86);
    rd(`DWR_OFS_PRESET, 0, OK);
  endtask
  // Clear wins over loads and presets, memory emptied too
  task automatic t_clear;
    wr(`DWR_OFS_HOLD, 32'hff, OK);
    wr(`DWR_OFS_DATA, 32'h5a, OK);
    wr(`DWR_OFS_MEM + 7'h04, 32'h1234abcd, OK);
    rd(`DWR_OFS_MEM + 7'h04, 32'h1234abcd, OK);
    wr(`DWR_OFS_CTRL, 32'h1, OK);
    hold_low <= 1'b1;
    repeat (5) @(posedge clk);
    chk(cells, 8'h00);
    wr(`DWR_OFS_DATA, 32'hff, OK);
    wr(`DWR_OFS_PRESET, 32'hff, OK);
    chk(cells, 8'h00);
    rd(`DWR_OFS_STATUS, 32'h1, OK);
    hold_low <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`DWR_OFS_MEM + 7'h04, 0, OK);
    rd(`DWR_OFS_STATUS, 32'h2, OK);
  endtask
  // Gate and power-down requests leave through registers
  task automatic t_gate;
    wr(`DWR_OFS_CTRL, 32'h6, OK);
    @(posedge clk);
    chk({gate, pwrdn}, 2'b11);
    rd(`DWR_OFS_STATUS, 32'he, OK);
    wr(`DWR_OFS_CTRL, 32'h0, OK);
  endtask
  // Unmapped place refuses both ways
  task automatic t_unmapped;
    rd(7'h20, 0, ER);
    wr(7'h20, 32'h1, ER);
  endtask
  // Clear disabled: the pin is a user output and a low level clears nothing
  // The earlier clear emptied the hold mask, so it is opened again first
  task automatic t_userpin;
    wr(`DWR_OFS_HOLD, 32'hff, OK);
    wr(`DWR_OFS_DATA, 32'h3c, OK);
    wr(`DWR_OFS_PIN, 32'h2, OK);
    chk({poe, pout}, 2'b10);
    repeat (4) @(posedge clk);
    chk(cells, 8'h3c);
    wr(`DWR_OFS_PIN, 32'h0, OK);
  endtask
  // Reset in mid-run brings back the power-up levels and the default map
  task automatic t_rereset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(cells, PUP);
    chk({poe, gate, pwrdn}, 3'h0);
    rd(`DWR_OFS_HOLD, 0, OK);
  endtask
  // ==========================================================
  // Verdict, reached from the main flow or the timeout
  task automatic results;
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Ceiling well above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    rst = 1'b1;
    {awv, wv, brdy, arv, rrdy, hold_low} = 6'h00;
    awa = 7'h00;
    ara = 7'h00;
    wd = 32'h0;
    ws = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_powerup;
    t_hold;
    t_clear;
    t_gate;
    t_unmapped;
    t_userpin;
    t_rereset;
    results;
  end
endmodule
